// File: core/blc_pkg.sv
// Constants, register map and mode encodings of the backlight boost control
// Assumes a 125 MHz system clock shared by every user of this package
package blc_pkg;

  localparam int N_CH           = 4;
  localparam int AXI_AW         = 8;
  localparam int CLK_KHZ        = 125000;
  localparam int CLK_MHZ        = 125;
  localparam int DETECT_CYC     = 2048;
  localparam int SYNC_EDGES_MIN = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BRIGHT = 8'h04;
  localparam logic [7:0] OFS_CUR0   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_INFO   = 8'h1C;

  // Control fields and reset values
  localparam int         CTRL_SRC_BIT  = 0;
  localparam int         CTRL_PIRQ_BIT = 1;
  localparam logic       SRC_RST       = 1'b0;
  localparam logic       PIRQ_RST      = 1'b1;
  localparam int         CUR_W         = 12;
  localparam logic [11:0] CUR_RST      = 12'hFFF;
  localparam int         BRIGHT_W      = 16;
  localparam logic [15:0] BRIGHT_RST   = 16'hFFFF;

  // Fault status layout
  localparam int FLT_OPEN_LSB  = 0;
  localparam int FLT_SHORT_LSB = 4;
  localparam int FLT_GND_LSB   = 8;
  localparam int FLT_GLOB_LSB  = 12;
  localparam int N_GLOB        = 8;
  localparam int FLT_PUMP_BIT  = 20;
  localparam int FLT_W         = 21;

  // Info layout
  localparam int INFO_CAP_BIT    = 0;
  localparam int INFO_PUMP_BIT   = 1;
  localparam int INFO_EXT_BIT    = 2;
  localparam int INFO_SPREAD_BIT = 3;
  localparam int INFO_STR_LSB    = 4;
  localparam int INFO_FREQ_LSB   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Boost timing
  localparam int FREQ_HI_KHZ   = 1818;
  localparam int MIN_ON_LO_NS  = 150;
  localparam int MIN_OFF_LO_NS = 150;
  localparam int MIN_ON_HI_NS  = 110;
  localparam int MIN_OFF_HI_NS = 40;
  localparam logic [15:0] MIN_ON_LO_CYC  = 16'((MIN_ON_LO_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] MIN_OFF_LO_CYC = 16'((MIN_OFF_LO_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] MIN_ON_HI_CYC  = 16'((MIN_ON_HI_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] MIN_OFF_HI_CYC = 16'((MIN_OFF_HI_NS * CLK_MHZ + 999) / 1000);
  localparam logic [33:0] PHASE_THIRD    = 34'h0000_5556;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_DETECT = 3'b010,
    ST_RUN    = 3'b100
  } blc_state_e;

  // Set-resistor code to boost frequency, codes in resistor order
  function automatic int blc_freq_khz(input logic [2:0] code);
    int f;
    f = 0;
    unique case (code)
      3'h0: f = 400;
      3'h1: f = 200;
      3'h2: f = 303;
      3'h3: f = 100;
      3'h4: f = 500;
      3'h5: f = 1818;
      3'h6: f = 2000;
      3'h7: f = 2222;
    endcase
    return f;
  endfunction : blc_freq_khz

  function automatic logic [15:0] blc_period(input logic [2:0] code);
    return 16'(CLK_KHZ / blc_freq_khz(code));
  endfunction : blc_period

endpackage : blc_pkg

// File: core/blc_top.sv
// Backlight boost control: strap capture, dimming, boost gate, fault status
// Assumes pins and analog comparators arrive asynchronous to aclk
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RQ1] Faults clear by bus write or enable fall
// [RQ2] Brightness from PWM duty, optionally from bus
// [RQ3] Per-channel current scale written over bus
// [RQ4] Phase mode chosen from string count strap
// [RQ5] Phases spaced by period over string count
// [RQ6] Unused outputs off, no LED faults
// [RQ7] System grounds unused LED outputs
// [RQ8] Detect external boost clock at start-up
// [RQ9] Static sync level selects spread spectrum
// [RQ10] Enable pin turns device on and off
// [RQ11] Bus and faults inactive while disabled
// [RQ12] Open-drain interrupt signals faults
// [RQ13] Pump enabled unless supply tied to it
// [RQ14] Pump cap status and pump fault bit
// [RQ15] Pump irq enable gates pump fault interrupt
// [RQ16] Current limit ends switch pulse at once
// [RQ17] Current limit raises no status
// [RQ18] Boost frequency from set-resistor code
// [RQ19] Eight codes map to eight frequencies
// [RQ20] Low band: 150 ns min on and off; code keeps min off only with internal clock
// [RQ21] High band: 40 ns off, 110 ns on; code keeps min off only with internal clock
// [RQ22] Detect LED and system fault conditions
// [RQ23] Fault bits stay set until cleared
module blc_top #(
  parameter int DETECT_CYC = blc_pkg::DETECT_CYC
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [blc_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [blc_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          en_pin,
  input  wire logic                          pwm_in,
  input  wire logic                          boost_clock_sync_in,
  input  wire logic [2:0]                    string_config_select,
  input  wire logic [2:0]                    boost_freq_select,
  input  wire logic                          pump_output_pin_tied,
  input  wire logic                          pump_cap_sense,
  input  wire logic                          pump_fault_sense,
  input  wire logic                          switch_current_sense,
  input  wire logic [blc_pkg::N_CH-1:0]      led_open,
  input  wire logic [blc_pkg::N_CH-1:0]      led_short,
  input  wire logic [blc_pkg::N_CH-1:0]      led_gnd_short,
  input  wire logic [blc_pkg::N_GLOB-1:0]    sys_fault,
  input  wire logic [15:0]                   boost_on_demand,
  output logic                               int_o,
  output logic                               int_oe,
  output logic                               boost_gate,
  output logic                               pump_enable,
  output logic                               spread_enable,
  output logic [blc_pkg::N_CH-1:0]           chan_enable,
  output logic [blc_pkg::N_CH-1:0]           chan_pwm,
  output logic [blc_pkg::N_CH*blc_pkg::CUR_W-1:0] channel_current_scale
);
  import blc_pkg::*;

  localparam int SW = 13 + 3 * N_CH + N_GLOB;

  // Pin synchroniser
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s1;
  logic [SW-1:0] pin_s2;
  logic          en_s;
  logic          pwm_s;
  logic          sync_s;
  logic [2:0]    str_s;
  logic [2:0]    freq_s;
  logic          tied_s;
  logic          cap_s;
  logic          pfault_s;
  logic          ilim_s;
  logic [N_CH-1:0]   open_s;
  logic [N_CH-1:0]   short_s;
  logic [N_CH-1:0]   gnd_s;
  logic [N_GLOB-1:0] glob_s;

  assign pin_raw = {en_pin, pwm_in, boost_clock_sync_in, string_config_select,
                    boost_freq_select, pump_output_pin_tied, pump_cap_sense,
                    pump_fault_sense, switch_current_sense, led_open,
                    led_short, led_gnd_short, sys_fault};
  assign {en_s, pwm_s, sync_s, str_s, freq_s, tied_s, cap_s, pfault_s,
          ilim_s, open_s, short_s, gnd_s, glob_s} = pin_s2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] phase_ofs(input logic [15:0] per,
                                            input logic [1:0]  idx,
                                            input logic [2:0]  cnt);
    logic [33:0] p;
    p = 34'(per) * 34'(idx);
    unique case (cnt)
      3'd1: p = 34'h0;
      3'd2: p = p >> 1;
      3'd3: p = (p * PHASE_THIRD) >> 16;
      3'd4: p = p >> 2;
      default: p = 34'h0;
    endcase
    return p[15:0];
  endfunction : phase_ofs

  // Enable, start-up detection and strap capture
  blc_state_e  state_reg;
  logic        en_prev_reg;
  logic [15:0] det_cnt_reg;
  logic [1:0]  edge_cnt_reg;
  logic        sync_prev_reg;
  logic        ext_clk_reg;
  logic [2:0]  str_cnt_reg;
  logic [2:0]  freq_reg;
  logic        running;
  logic        sync_rise;

  assign running   = (state_reg == ST_RUN);
  assign sync_rise = sync_s & ~sync_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || !en_s) begin // see [RQ10]
      state_reg     <= ST_OFF;
      det_cnt_reg   <= 16'h0000;
      edge_cnt_reg  <= 2'h0;
      ext_clk_reg   <= 1'b0;
      spread_enable <= 1'b0;
      pump_enable   <= 1'b0;
      str_cnt_reg   <= 3'h1;
      freq_reg      <= 3'h0;
      chan_enable   <= '0;
    end else begin
      unique case (state_reg)
        ST_OFF: state_reg <= ST_DETECT;
        ST_DETECT: begin
          det_cnt_reg <= det_cnt_reg + 16'h0001;
          if (sync_rise && edge_cnt_reg != 2'h3)
            edge_cnt_reg <= edge_cnt_reg + 2'h1; // see [RQ8]
          if (det_cnt_reg == 16'(DETECT_CYC - 1)) begin
            state_reg   <= ST_RUN;
            ext_clk_reg <= (edge_cnt_reg >= 2'(SYNC_EDGES_MIN));
            spread_enable <= (edge_cnt_reg < 2'(SYNC_EDGES_MIN))
                             & sync_s; // see [RQ9]
            pump_enable <= ~tied_s; // see [RQ13]
            str_cnt_reg <= 3'({1'b0, str_s[1:0]}) + 3'h1; // see [RQ4]
            freq_reg    <= freq_s; // see [RQ18]
            for (int i = 0; i < N_CH; i++) begin
              chan_enable[i] <= (3'(i) < 3'({1'b0, str_s[1:0]}) + 3'h1);
            end
          end
        end
        ST_RUN: state_reg <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_prev_reg   <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      en_prev_reg   <= en_s;
      sync_prev_reg <= sync_s;
    end
  end

  // AXI4-Lite slave
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_do;
  logic        ar_fire;
  logic        ctrl_src_reg;
  logic        pump_irq_en_reg;
  logic [15:0] bright_reg;
  logic [CUR_W-1:0] cur_reg [N_CH];
  logic [FLT_W-1:0] fault_reg;
  logic [FLT_W-1:0] clr_vec;
  logic [31:0] wmerged;

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_INFO);
  endfunction : mapped

  assign wr_do   = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign wmerged = merge(32'h0, w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (en_s && mapped(aw_addr_reg)) ? RESP_OKAY
                                                      : RESP_SLVERR; // see [RQ11]
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= (en_s && mapped(s_axi_araddr)) ? RESP_OKAY
                                                      : RESP_SLVERR; // see [RQ11]
      s_axi_rdata   <= 32'h0000_0000;
      if (en_s) begin
        unique case (s_axi_araddr)
          OFS_CTRL:   s_axi_rdata <= 32'({pump_irq_en_reg, ctrl_src_reg});
          OFS_BRIGHT: s_axi_rdata <= 32'(bright_reg);
          OFS_STATUS: s_axi_rdata <= 32'(fault_reg);
          OFS_INFO:   s_axi_rdata <= 32'({freq_reg, 1'b0, str_cnt_reg,
                                          spread_enable, ext_clk_reg,
                                          pump_enable,
                                          pump_enable & cap_s}); // see [RQ14]
          default: begin
            for (int i = 0; i < N_CH; i++) begin
              if (s_axi_araddr == OFS_CUR0 + 8'(4 * i))
                s_axi_rdata <= 32'(cur_reg[i]);
            end
          end
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Configuration registers, back to reset values while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_s) begin // see [RQ11]
      ctrl_src_reg    <= SRC_RST;
      pump_irq_en_reg <= PIRQ_RST;
      bright_reg      <= BRIGHT_RST;
      for (int i = 0; i < N_CH; i++) cur_reg[i] <= CUR_RST;
    end else if (wr_do) begin
      if (aw_addr_reg == OFS_CTRL) begin
        if (w_strb_reg[0]) begin
          ctrl_src_reg    <= w_data_reg[CTRL_SRC_BIT]; // see [RQ2]
          pump_irq_en_reg <= w_data_reg[CTRL_PIRQ_BIT]; // see [RQ15]
        end
      end
      if (aw_addr_reg == OFS_BRIGHT) begin
        if (w_strb_reg[0]) bright_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) bright_reg[15:8] <= w_data_reg[15:8];
      end
      for (int i = 0; i < N_CH; i++) begin
        if (aw_addr_reg == OFS_CUR0 + 8'(4 * i)) begin
          if (w_strb_reg[0]) cur_reg[i][7:0] <= w_data_reg[7:0]; // see [RQ3]
          if (w_strb_reg[1]) cur_reg[i][11:8] <= w_data_reg[11:8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_current_scale <= '0;
    end else begin
      for (int i = 0; i < N_CH; i++)
        channel_current_scale[i*CUR_W +: CUR_W] <= cur_reg[i]; // see [RQ3]
    end
  end

  // Sticky fault status and interrupt
  logic [FLT_W-1:0] flt_set;
  logic             irq_pend;

  assign clr_vec = (wr_do && aw_addr_reg == OFS_STATUS) ? wmerged[FLT_W-1:0]
                                                        : '0; // see [RQ1]
  assign flt_set = running ? {pfault_s & pump_enable, // see [RQ14]
                              glob_s, // see [RQ22]
                              gnd_s & chan_enable,
                              short_s & chan_enable,
                              open_s & chan_enable} // see [RQ6]
                           : '0;
  assign irq_pend = (|fault_reg[FLT_PUMP_BIT-1:0])
                  | (fault_reg[FLT_PUMP_BIT] & pump_irq_en_reg); // see [RQ15]

  always_ff @(posedge aclk) begin
    if (!aresetn || !en_s) begin // see [RQ1]
      fault_reg <= '0;
    end else begin
      fault_reg <= (fault_reg & ~clr_vec) | flt_set; // see [RQ23]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_o  <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      int_o  <= 1'b0;
      int_oe <= en_s & irq_pend; // see [RQ12]
    end
  end

  // PWM input duty measurement
  logic        pwm_prev_reg;
  logic [15:0] per_cnt_reg;
  logic [15:0] high_cnt_reg;
  logic [15:0] meas_per_reg;
  logic [15:0] meas_high_reg;
  logic [15:0] dim_per;
  logic [15:0] dim_duty;
  logic [15:0] dim_cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || !en_s) begin
      pwm_prev_reg  <= 1'b0;
      per_cnt_reg   <= 16'h0000;
      high_cnt_reg  <= 16'h0000;
      meas_per_reg  <= 16'hFFFF;
      meas_high_reg <= 16'h0000;
    end else begin
      pwm_prev_reg <= pwm_s;
      if (pwm_s && !pwm_prev_reg) begin
        meas_per_reg  <= per_cnt_reg;
        meas_high_reg <= high_cnt_reg;
        per_cnt_reg   <= 16'h0001;
        high_cnt_reg  <= 16'h0001;
      end else if (per_cnt_reg == 16'hFFFF) begin
        meas_per_reg  <= 16'hFFFF;
        meas_high_reg <= pwm_s ? 16'hFFFF : 16'h0000;
      end else begin
        per_cnt_reg  <= per_cnt_reg + 16'h0001;
        high_cnt_reg <= high_cnt_reg + 16'(pwm_s);
      end
    end
  end

  assign dim_per  = ctrl_src_reg ? 16'hFFFF : meas_per_reg; // see [RQ2]
  assign dim_duty = ctrl_src_reg ? bright_reg : meas_high_reg;

  // Phase-shifted channel dimming
  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      dim_cnt_reg <= 16'h0000;
      chan_pwm    <= '0;
    end else begin
      dim_cnt_reg <= (dim_cnt_reg + 16'h0001 >= dim_per) ? 16'h0000
                                                        : dim_cnt_reg + 16'h0001;
      for (int i = 0; i < N_CH; i++) begin
        logic [16:0] pos;
        pos = 17'(dim_cnt_reg) + 17'(phase_ofs(dim_per, 2'(i),
                                              str_cnt_reg)); // see [RQ5]
        if (pos >= 17'(dim_per)) pos = pos - 17'(dim_per);
        chan_pwm[i] <= chan_enable[i] & (pos < 17'(dim_duty)); // see [RQ6]
      end
    end
  end

  // Boost switch gate
  logic [15:0] bst_cnt_reg;
  logic [7:0]  lfsr_reg;
  logic [15:0] bst_per;
  logic [15:0] min_on;
  logic [15:0] min_off;
  logic [15:0] on_len;
  logic        hi_band;
  logic        restart;

  assign hi_band = blc_freq_khz(freq_reg) >= FREQ_HI_KHZ;
  assign min_on  = hi_band ? MIN_ON_HI_CYC : MIN_ON_LO_CYC; // see [RQ21]
  assign min_off = hi_band ? MIN_OFF_HI_CYC : MIN_OFF_LO_CYC; // see [RQ20]
  assign bst_per = blc_period(freq_reg)
                 + (spread_enable ? 16'(lfsr_reg[3:0]) : 16'h0000); // see [RQ19]
  assign on_len  = (boost_on_demand > min_on) ? boost_on_demand : min_on;
  assign restart = ext_clk_reg ? sync_rise
                               : (bst_cnt_reg + 16'h0001 >= bst_per); // see [RQ8]

  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      bst_cnt_reg <= 16'h0000;
      boost_gate  <= 1'b0;
      lfsr_reg    <= 8'h01;
    end else if (restart) begin
      bst_cnt_reg <= 16'h0000;
      boost_gate  <= (boost_on_demand != 16'h0000);
      lfsr_reg    <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5]
                      ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end else begin
      if (bst_cnt_reg != 16'hFFFF) bst_cnt_reg <= bst_cnt_reg + 16'h0001;
      // Limit trip ends the pulse, no status is touched
      if (ilim_s) boost_gate <= 1'b0; // see [RQ16] see [RQ17]
      else if (bst_cnt_reg + 16'h0001 >= on_len) boost_gate <= 1'b0;
      else if (bst_cnt_reg + 16'h0002 + min_off >= bst_per && !ext_clk_reg)
        boost_gate <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] off_len_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || boost_gate) off_len_reg <= 16'h0000;
    else if (off_len_reg != 16'hFFFF) off_len_reg <= off_len_reg + 16'h0001;
  end

  sequence s_trip;
    boost_gate && ilim_s && !restart;
  endsequence
  sequence s_wr_off;
    wr_do && !en_s;
  endsequence

  property p_trip_off;
    s_trip |=> !boost_gate;
  endproperty
  a_trip_off: assert property (p_trip_off) // see [RQ16]
    else $error("gate stayed on after current limit trip");

  property p_min_off;
    $rose(boost_gate) && !ext_clk_reg && $past(running)
      |-> $past(off_len_reg) + 16'h0001 >= min_off;
  endproperty
  a_min_off: assert property (p_min_off) // see [RQ20]
    else $error("switch off time below minimum");

  property p_en_fall;
    (en_prev_reg && !en_s) |=> fault_reg == '0;
  endproperty
  a_en_fall: assert property (p_en_fall) // see [RQ1]
    else $error("faults not cleared on enable fall");

  property p_sticky;
    (en_s && clr_vec == '0) |=> ((fault_reg & $past(fault_reg))
                                 == $past(fault_reg));
  endproperty
  a_sticky: assert property (p_sticky) // see [RQ23]
    else $error("fault bit dropped without clear");

  property p_pump_mask;
    (!pump_irq_en_reg && fault_reg[FLT_PUMP_BIT-1:0] == '0) |=> !int_oe;
  endproperty
  a_pump_mask: assert property (p_pump_mask) // see [RQ15]
    else $error("masked pump fault drove interrupt");

  property p_int_on;
    (en_s && (fault_reg[FLT_PUMP_BIT-1:0] != '0
              || (fault_reg[FLT_PUMP_BIT] && pump_irq_en_reg))) |=> int_oe;
  endproperty
  a_int_on: assert property (p_int_on) // see [RQ12]
    else $error("fault present but interrupt released");

  property p_unused_flt;
    ((fault_reg[N_CH-1:0] | fault_reg[FLT_SHORT_LSB +: N_CH]
      | fault_reg[FLT_GND_LSB +: N_CH]) & ~chan_enable) == '0;
  endproperty
  a_unused_flt: assert property (p_unused_flt) // see [RQ6]
    else $error("fault reported on unused channel");

  property p_bus_off;
    s_wr_off |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_bus_off: assert property (p_bus_off) // see [RQ11]
    else $error("bus write accepted while disabled");

  property p_no_boost_off;
    !en_s |=> ##1 !boost_gate && chan_pwm == '0;
  endproperty
  a_no_boost_off: assert property (p_no_boost_off) // see [RQ10]
    else $error("outputs active while disabled");

endmodule : blc_top

`default_nettype wire

// File: verif/blc_host_model.sv
// Host side of the pins: dimming source, sync strap, interrupt pull-up
// Assumes one shared aclk; the sync pin is strapped high, or toggled from aclk while sync_run is high
`timescale 1ns/1ps
`default_nettype none
module blc_host_model (
  input  wire logic aclk,
  input  wire logic int_oe,
  input  wire logic sync_run,
  output logic      pwm_in,
  output logic      boost_clock_sync_in,
  output logic      int_n
);
  int cnt = 0;
  // Static high asks for spread, toggling acts as external clock
  assign boost_clock_sync_in = sync_run ? cnt[2] : 1'b1;
  // Pull-up on the open-drain line
  assign int_n = !int_oe;
  // Dimming source, 30 percent duty
  always @(posedge aclk) begin
    cnt    <= (cnt + 1) % 100;
    pwm_in <= (cnt < 30);
  end
endmodule : blc_host_model
`default_nettype wire

// File: verif/backlight_boost_control_test.sv
// Testbench of the backlight boost control: bus, straps, faults
// Assumes blc_pkg, blc_top and blc_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module backlight_boost_control_test;
  import blc_pkg::*;
  logic        aclk = 0, aresetn = 0, en = 0, awv = 0, wv = 0, bre = 0;
  logic        arv = 0, rre = 0, pfs = 0, csn = 0, cap = 1, tie = 0;
  logic        awr, wr_, bv, arr, rv, ioe, pwm, sync, int_n;
  logic        srun = 0, io, bg, pen, spen;
  logic [1:0]  br, rr;
  logic [2:0]  scfg = 0, fsel = 0;
  logic [3:0]  lop = 0, chen, cpwm;
  logic [7:0]  awa = 0, ara = 0, sf = 0;
  logic [15:0] dem = 0;
  logic [31:0] wd = 0, rdq, rdat, d;
  logic [47:0] scl;
  logic [31:0] mdl [int];
  int          fail_count = 0, cmp_count = 0, n;
  always #4 aclk = ~aclk;
  blc_top #(.DETECT_CYC(64)) blc_top_inst (.aclk, .aresetn,
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdq), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .en_pin(en), .pwm_in(pwm),
    .boost_clock_sync_in(sync), .string_config_select(scfg),
    .boost_freq_select(fsel), .pump_output_pin_tied(tie),
    .pump_cap_sense(cap), .pump_fault_sense(pfs),
    .switch_current_sense(csn), .led_open(lop), .led_short(lop),
    .led_gnd_short(lop), .sys_fault(sf), .boost_on_demand(dem),
    .int_o(io), .int_oe(ioe), .boost_gate(bg), .pump_enable(pen),
    .spread_enable(spen), .chan_enable(chen), .chan_pwm(cpwm),
    .channel_current_scale(scl));
  blc_host_model blc_host_model_inst (.aclk, .int_oe(ioe), .sync_run(srun),
    .pwm_in(pwm), .boost_clock_sync_in(sync), .int_n);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awa <= a;
    wd  <= v;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rdat = rdq;
    rre <= 1'b0;
  endtask : rd
  task results;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    results();
  end
  initial begin
    n = $urandom(32'h893F35A4);
    mdl[OFS_CTRL] = 32'h2;
    mdl[OFS_BRIGHT] = 32'hFFFF;
    mdl[OFS_CUR0] = 32'hFFF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    scfg <= 3'($urandom % 8);
    fsel <= 3'($urandom % 8);
    dem <= 16'($urandom);
    rd(OFS_CTRL);
    chk(rr, RESP_SLVERR);
    wr(OFS_CTRL, 32'h1);
    chk(br, RESP_SLVERR);
    en <= 1'b1;
    repeat (80) @(posedge aclk);
    n = scfg[1:0] + 1;
    chk(chen, (1 << n) - 1);
    rd(OFS_INFO);
    chk(rdat, 32'hB | n << 4 | fsel << 8);
    chk({pen, spen}, 2'b11);
    foreach (mdl[k]) begin
      rd(8'(k));
      chk(rdat, mdl[k]);
    end
    d = $urandom;
    wr(OFS_CUR0, d);
    rd(OFS_CUR0);
    chk(rdat, d & 32'hFFF);
    chk(scl[11:0], d & 32'hFFF);
    wr(OFS_CTRL, 32'h1);
    d = $urandom % 256;
    lop <= 4'hF;
    sf  <= d[7:0];
    csn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(cpwm, chen);
    lop <= 4'h0;
    sf  <= 8'h00;
    repeat (4) @(posedge aclk);
    rd(OFS_STATUS);
    chk(rdat, chen * 32'h111 | d << 12);
    chk(int_n, 1'b0);
    wr(OFS_STATUS, 32'h1FFFFF);
    csn <= 1'b0;
    pfs <= 1'b1;
    repeat (4) @(posedge aclk);
    pfs <= 1'b0;
    rd(OFS_STATUS);
    chk(rdat, 32'h100000);
    chk(int_n, 1'b1);
    wr(OFS_CTRL, 32'h3);
    repeat (3) @(posedge aclk);
    chk(int_n, 1'b0);
    rd(8'h20);
    chk(rr, RESP_SLVERR);
    chk(rdat, 32'h0);
    en <= 1'b0;
    tie <= 1'b1;
    srun <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({io, bg, cpwm}, 32'h0);
    en <= 1'b1;
    repeat (80) @(posedge aclk);
    rd(OFS_STATUS);
    chk(rdat, 32'h0);
    rd(OFS_INFO);
    chk(rdat, 32'h4 | n << 4 | fsel << 8);
    chk({pen, spen}, 2'b00);
    results();
  end
endmodule : backlight_boost_control_test
`default_nettype wire
